// [bench/otpb_macro_model.sv]
/* Model of the two 16-bit macrocell banks behind the block.
   Assumes the command holds through the pulse; fails are tb commanded. */
`default_nettype none
module otpb_macro_model (
    input wire logic core_clk,
    input wire otpb_pkg::otpb_macro_cmd_type macroCmd,
    input wire logic failU,
    input wire logic failL,
    output var logic macroUpperFail,
    output var logic macroLowerFail
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:8191] = '{default: 32'h0000_0000};
    otpb_pkg::otpb_macro_cmd_type cmd_ff = '0;
    logic toggle_ff = 1'b0;
    logic verify;
    assign verify = cmd_ff.strobe && !macroCmd.strobe;
    // Off the verify cycle the results wander, so a mistimed sample shows
    assign macroUpperFail = verify ? failU : toggle_ff;
    assign macroLowerFail = verify ? failL : !toggle_ff;
    // Word is {U1,L1,U0,L0}; a failing bank keeps its old bit
    always @(posedge core_clk) begin
        toggle_ff <= !toggle_ff;
        cmd_ff <= macroCmd;
        if (verify && cmd_ff.upperEnable && !failU) begin
            mem[cmd_ff.wordAddr][cmd_ff.upperWordBit] <=
                cmd_ff.upperBitValue;
        end
        if (verify && cmd_ff.lowerEnable && !failL) begin
            mem[cmd_ff.wordAddr][cmd_ff.lowerWordBit] <=
                cmd_ff.lowerBitValue;
        end
    end
endmodule
`default_nettype wire

// [bench/otpb_sva.sv]
/* Checker for the bit-programming block: command pulse and status fields.
   Assumes it is bound to otpb_bit_program and sees only its ports. */
`default_nettype none
module otpb_sva #(
    parameter int PROG_CYC = otpb_pkg::PROG_CYCLES
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire otpb_pkg::otpb_axi_req_type axiReq,
    input wire otpb_pkg::otpb_axi_rsp_type axiRsp,
    input wire otpb_pkg::otpb_ctrl_in_type ctrlIn,
    input wire logic macroUpperFail,
    input wire logic macroLowerFail,
    input wire otpb_pkg::otpb_macro_cmd_type macroCmd,
    input wire logic [2:0] modeSel
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] stbCnt_ff;
    logic rdStat;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Pulse length counter; a repetition would not scale with PROG_CYC
    always_ff @(posedge core_clk) begin
        if (!nrst || !macroCmd.strobe) begin
            stbCnt_ff <= 16'h0000;
        end else begin
            stbCnt_ff <= stbCnt_ff + 16'h0001;
        end
    end
    // Status read accepted this cycle
    assign rdStat = axiReq.arvalid && axiRsp.arready &&
        axiReq.araddr == otpb_pkg::STAT_ADDR;
    chk_pulse_len: assert property (
        $fell(macroCmd.strobe) |-> stbCnt_ff == PROG_CYC)
        else $error("program pulse length wrong");
    chk_pulse_mode: assert property (
        $rose(macroCmd.strobe) |-> modeSel == 3'h2)
        else $error("program pulse outside manual program mode");
    chk_cmd_hold: assert property (
        macroCmd.strobe && $past(macroCmd.strobe) |-> $stable(macroCmd))
        else $error("command changed during pulse");
    chk_word_bit: assert property (
        macroCmd.strobe |-> macroCmd.upperWordBit[3]
        && !macroCmd.lowerWordBit[3])
        else $error("bank bit outside its byte lanes");
    chk_count_fields: assert property (
        rdStat |=> axiRsp.rdata[28:16] == $past(ctrlIn.wordsRemaining)
        && axiRsp.rdata[11:8] == $past(ctrlIn.fifoWordCount))
        else $error("status counts wrong");
    chk_test_err: assert property (
        rdStat |=> axiRsp.rdata[15:14] ==
        {$past(ctrlIn.testErrU), $past(ctrlIn.testErrL)}
        && axiRsp.rdata[3] == (axiRsp.rdata[15] | axiRsp.rdata[14]))
        else $error("test error bits wrong");
    chk_test_ready: assert property (
        rdStat |=> axiRsp.rdata[2] ==
        !($past(modeSel) >= 3'h5 && $past(ctrlIn.testBusy)))
        else $error("test ready wrong");
    chk_auto_ready: assert property (
        rdStat |=> axiRsp.rdata[4] == !(($past(modeSel) == 3'h3 ||
        $past(modeSel) == 3'h4) && $past(ctrlIn.autoBusy)))
        else $error("auto ready wrong");
    chk_prog_busy: assert property (
        rdStat && macroCmd.strobe |=> !axiRsp.rdata[0])
        else $error("program ready high during pulse");
    chk_perr_sum: assert property (
        rdStat |=> axiRsp.rdata[1] ==
        (axiRsp.rdata[13] | axiRsp.rdata[12]))
        else $error("program error summary wrong");
    cov_pulse: cover property ($rose(macroCmd.strobe));
    cov_fail: cover property ($fell(macroCmd.strobe) && macroUpperFail);
    cov_slverr: cover property (axiRsp.bvalid && axiRsp.bresp == 2'h2);
endmodule
bind otpb_bit_program otpb_sva #(.PROG_CYC(PROG_CYC)) u_otpb_sva (
    .core_clk(core_clk), .nrst(nrst), .axiReq(axiReq), .axiRsp(axiRsp),
    .ctrlIn(ctrlIn), .macroUpperFail(macroUpperFail),
    .macroLowerFail(macroLowerFail), .macroCmd(macroCmd),
    .modeSel(modeSel));
`default_nettype wire

// [bench/tb.sv]
/* Self-checking bench of the bit-programming block over AXI4-Lite.
   Assumes a short program pulse (PROG_CYC 2) and a banks model. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    otpb_pkg::otpb_axi_req_type axiReq = '0;
    otpb_pkg::otpb_axi_rsp_type axiRsp;
    otpb_pkg::otpb_ctrl_in_type ctrlIn = '0;
    otpb_pkg::otpb_macro_cmd_type macroCmd;
    logic [2:0] modeSel;
    logic upFail, loFail, failU = 1'b0, failL = 1'b0, eU = 1'b0, eL = 1'b0;
    logic [31:0] expMem [0:8191] = '{default: 32'h0000_0000};
    logic [31:0] seed = 32'd98074;
    int errCount = 0;
    int compares = 0;
    otpb_bit_program #(.PROG_CYC(2)) u_otpb_bit_program (
        .core_clk(core_clk), .nrst(nrst), .axiReq(axiReq),
        .axiRsp(axiRsp), .ctrlIn(ctrlIn), .macroUpperFail(upFail),
        .macroLowerFail(loFail), .macroCmd(macroCmd), .modeSel(modeSel));
    otpb_macro_model u_otpb_macro_model (
        .core_clk(core_clk), .macroCmd(macroCmd), .failU(failU),
        .failL(failL), .macroUpperFail(upFail), .macroLowerFail(loFail));
    // 25 MHz clock
    initial forever #20 core_clk = !core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Status expected from mode, side inputs and the last manual step
    function automatic logic [31:0] expStat(input int m);
        logic [31:0] s;
        logic pu, pl;
        pu = (m == 4) ? ctrlIn.autoProgErrU : eU;
        pl = (m == 4) ? ctrlIn.autoProgErrL : eL;
        s = '0;
        s[28:16] = ctrlIn.wordsRemaining;
        s[15:12] = {ctrlIn.testErrU, ctrlIn.testErrL, pu, pl};
        s[11:8] = ctrlIn.fifoWordCount;
        s[4] = !((m == 3 || m == 4) && ctrlIn.autoBusy);
        s[3] = ctrlIn.testErrU | ctrlIn.testErrL;
        s[2] = !(m >= 5 && ctrlIn.testBusy);
        s[1] = pu | pl;
        s[0] = !(m == 4 && ctrlIn.autoProgStep);
        return s;
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
        logic aw, w;
        aw = 0;
        w = 0;
        axiReq.awaddr <= a;
        axiReq.wdata <= d;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge core_clk);
            if (!aw && axiRsp.awready) begin
                aw = 1;
                axiReq.awvalid <= 1'b0;
            end
            if (!w && axiRsp.wready) begin
                w = 1;
                axiReq.wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (axiRsp.bvalid !== 1'b1);
        r = axiRsp.bresp;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        do @(posedge core_clk); while (axiRsp.arready !== 1'b1);
        axiReq.arvalid <= 1'b0;
        do @(posedge core_clk); while (axiRsp.rvalid !== 1'b1);
        d = axiRsp.rdata;
        r = axiRsp.rresp;
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, errors %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog: the run needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge core_clk);
        errCount++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d, s;
        logic [1:0] r;
        int a, up, lp;
        axiReq.wstrb <= 4'hF;
        axiReq.bready <= 1'b1;
        axiReq.rready <= 1'b1;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        rd(otpb_pkg::PCTRL_ADDR, d, r);
        check("ctrl reset", d, 32'h0000_0000);
        rd(otpb_pkg::STAT_ADDR, d, r);
        check("stat reset", d, expStat(0));
        // Standby writes must not program; manual program mode must
        for (int j = 0; j < 2; j++) begin
            wr(otpb_pkg::MODE_ADDR, j * 2, r);
            for (int i = 0; i < 8; i++) begin
                seed = lfsr(seed);
                d = seed & otpb_pkg::PCTRL_MASK;
                failU <= seed[31] & seed[30];
                failL <= seed[29] & seed[28];
                wr(otpb_pkg::PCTRL_ADDR, d, r);
                do rd(otpb_pkg::STAT_ADDR, s, r); while (s[0] !== 1'b1);
                a = d[12:0];
                up = (d[23] ? 24 : 8) + d[22:20];
                lp = (d[19] ? 16 : 0) + d[18:16];
                if (j == 1) begin
                    eU = failU & d[27];
                    eL = failL & d[25];
                    if (d[27] && !failU) expMem[a][up] = d[26];
                    if (d[25] && !failL) expMem[a][lp] = d[24];
                end
                check("word", u_otpb_macro_model.mem[a], expMem[a]);
                check("stat prog", s, expStat(j * 2));
                rd(otpb_pkg::PCTRL_ADDR, s, r);
                check("ctrl back", s, d);
            end
        end
        // Every mode with random side inputs
        for (int m = 0; m < 8; m++) begin
            wr(otpb_pkg::MODE_ADDR, m, r);
            rd(otpb_pkg::MODE_ADDR, d, r);
            check("mode", d, m);
            check("mode pin", {29'h0, modeSel}, m);
            repeat (3) begin
                seed = lfsr(seed);
                ctrlIn <= seed[23:0];
                rd(otpb_pkg::STAT_ADDR, d, r);
                check("stat", d, expStat(m));
            end
        end
        wr(otpb_pkg::STAT_ADDR, ~seed, r);
        check("stat wr resp", r, otpb_pkg::RESP_OKAY);
        rd(otpb_pkg::STAT_ADDR, d, r);
        check("stat kept", d, expStat(7));
        rd(32'h4000_800C, d, r);
        check("unmapped rd", {d[29:0], r}, otpb_pkg::RESP_SLVERR);
        wr(32'h4000_800C, seed, r);
        check("unmapped wr", r, otpb_pkg::RESP_SLVERR);
        // Byte strobes: only lane 0 of an all-ones write lands
        wr(otpb_pkg::PCTRL_ADDR, 32'h0000_0000, r);
        axiReq.wstrb <= 4'h1;
        wr(otpb_pkg::PCTRL_ADDR, 32'hFFFF_FFFF, r);
        axiReq.wstrb <= 4'hF;
        rd(otpb_pkg::PCTRL_ADDR, d, r);
        check("ctrl lane", d, 32'h0000_00FF);
        wrap_up();
    end
endmodule
`default_nettype wire

// [hw/otpb_bit_program.sv]
/*
 * Bit-programming control and status of the one-time-programmable memory
 * controller, with its AXI4-Lite register slave.
 * Assumes the automatic sequencer, FIFO and macrocell banks run on
 * core_clk, so their signals enter without synchronisers.
 */
// Design decision made here: register access over AXI4-Lite.
`default_nettype none

// Notes on behaviour
// - Lower bank programmed only when its enable set
// - Lower bit value is lower bank target
// - Upper byte select picks U1 or U0
// - Upper bit index picks bit in byte
// - Lower byte select picks L1 or L0
// - Lower bit index picks bit in byte
// - Word address locates the 32-bit word
// - Word byte order is U1 L1 U0 L0
// - Status reports words remaining, reset zero; here passed straight from ctrlIn.wordsRemaining, not cleared by nrst
// - Per-bank test error flags in status
// - Per-bank programming error flags in status
// - Status reports FIFO word count
// - Auto ready low while automatic mode busy
// - Test error flag valid once test ready
// - Test ready low while test runs
// - Programming error flag set when programming fails
// - Program ready low during programming step
// - Mode field encodes standby through write test
// - Upper bank enable and upper bit value
module otpb_bit_program #(
    parameter int PROG_CYC = otpb_pkg::PROG_CYCLES
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire otpb_pkg::otpb_axi_req_type axiReq,
    output var otpb_pkg::otpb_axi_rsp_type axiRsp,
    input wire otpb_pkg::otpb_ctrl_in_type ctrlIn,
    input wire logic macroUpperFail,
    input wire logic macroLowerFail,
    output var otpb_pkg::otpb_macro_cmd_type macroCmd,
    output var logic [2:0] modeSel
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (PROG_CYC < 1 || PROG_CYC > 65535) begin : gBadCyc
        $error("PROG_CYC must lie between 1 and 65535");
    end
    // A base above 24 pushes a bit index past 31
    if (otpb_pkg::UPPER_HI_LSB > 24 ||
        otpb_pkg::LOWER_HI_LSB > 24) begin : gBadLane
        $error("Byte base leaves no room for the index");
    end
    if (|(otpb_pkg::PCTRL_RESET & ~otpb_pkg::PCTRL_MASK)) begin : gBadRst
        $error("Control reset value sets reserved bits");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Whole state, registered in one always_ff
    typedef struct packed {
        otpb_pkg::otpb_axi_rsp_type rsp;
        logic awPend;
        logic [31:0] awAddr;
        logic wPend;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic [31:0] pctrl;
        otpb_pkg::otpb_mode_type mode;
        otpb_pkg::otpb_phase_type phase;
        logic [15:0] cnt;
        logic progErrU;
        logic progErrL;
        otpb_pkg::otpb_macro_cmd_type cmd;
    } otpb_state_type;

    // Registered state and its next value
    otpb_state_type cur_ff;
    otpb_state_type nxt_cur;
    logic [31:0] statusWord;
    logic [31:0] newPctrl;
    logic [31:0] newMode;
    logic autoMode;
    logic testMode;
    logic errU;
    logic errL;

    localparam logic [15:0] PULSE_LAST = 16'(PROG_CYC - 1);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [31:0] mask
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    // Position of a bank byte bit in the 32-bit word {U1,L1,U0,L0}
    function automatic logic [4:0] wordBit(
        input logic upper,
        input logic byteSel,
        input logic [2:0] idx
    );
        logic [4:0] base;
        if (upper) begin
            base = byteSel ? 5'(otpb_pkg::UPPER_HI_LSB)
                           : 5'(otpb_pkg::UPPER_LO_LSB);
        end else begin
            base = byteSel ? 5'(otpb_pkg::LOWER_HI_LSB)
                           : 5'(otpb_pkg::LOWER_LO_LSB);
        end
        return base + {2'h0, idx};
    endfunction

    // Step logic is idle: no pulse, no verify
    function automatic logic stepIdle(input otpb_pkg::otpb_phase_type ph);
        return ph == otpb_pkg::PH_IDLE;
    endfunction

    // Automatic program mode owns errors and ready
    function automatic logic autoProg(input otpb_pkg::otpb_mode_type md);
        return md == otpb_pkg::MODE_AUTO_PROG;
    endfunction

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    // Automatic and test sequencers report through ctrlIn; in automatic
    // program mode the automatic program error flags replace the manual ones.
    always_comb begin
        autoMode = (cur_ff.mode == otpb_pkg::MODE_AUTO_READ) ||
                   (cur_ff.mode == otpb_pkg::MODE_AUTO_PROG);
        testMode = (cur_ff.mode == otpb_pkg::MODE_BLANK_TEST) ||
                   (cur_ff.mode == otpb_pkg::MODE_DECODE_TEST) ||
                   (cur_ff.mode == otpb_pkg::MODE_WRITE_TEST);
        if (autoProg(cur_ff.mode)) begin
            errU = ctrlIn.autoProgErrU;
            errL = ctrlIn.autoProgErrL;
        end else begin
            errU = cur_ff.progErrU;
            errL = cur_ff.progErrL;
        end
        // Reserved bits 31:29 and 7:5 read zero
        statusWord = 32'h0000_0000;
        statusWord[28:16] = ctrlIn.wordsRemaining;
        statusWord[15] = ctrlIn.testErrU;
        statusWord[14] = ctrlIn.testErrL;
        statusWord[13] = errU;
        statusWord[12] = errL;
        statusWord[11:8] = ctrlIn.fifoWordCount;
        statusWord[4] = ~(autoMode & ctrlIn.autoBusy);
        // Error only meaningful after test ready returns high
        statusWord[3] = ctrlIn.testErrU | ctrlIn.testErrL;
        statusWord[2] = ~(testMode & ctrlIn.testBusy);
        statusWord[1] = errU | errL;
        // Program ready follows the automatic steps too, so it may toggle
        statusWord[0] = stepIdle(cur_ff.phase) &&
            !(autoProg(cur_ff.mode) &&
              ctrlIn.autoProgStep);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        // Lane-merged candidates for both writable registers
        newPctrl = mergeBytes(cur_ff.pctrl, cur_ff.wData, cur_ff.wStrb,
                              otpb_pkg::PCTRL_MASK);
        newMode = mergeBytes({29'h0, cur_ff.mode}, cur_ff.wData,
                             cur_ff.wStrb, otpb_pkg::MODE_MASK);

        // Address and data are taken independently, in either order
        if (axiReq.awvalid && cur_ff.rsp.awready) begin
            nxt_cur.awPend = 1'b1;
            nxt_cur.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && cur_ff.rsp.wready) begin
            nxt_cur.wPend = 1'b1;
            nxt_cur.wData = axiReq.wdata;
            nxt_cur.wStrb = axiReq.wstrb;
        end
        // Response leaves on bready
        if (cur_ff.rsp.bvalid && axiReq.bready) begin
            nxt_cur.rsp.bvalid = 1'b0;
        end

        // Commit a write once both halves are held
        if (cur_ff.awPend && cur_ff.wPend && !cur_ff.rsp.bvalid) begin
            nxt_cur.awPend = 1'b0;
            nxt_cur.wPend = 1'b0;
            nxt_cur.rsp.bvalid = 1'b1;
            nxt_cur.rsp.bresp = otpb_pkg::RESP_OKAY;
            // Mode changes are not policed;
            // going via standby is up to software
            case (cur_ff.awAddr)
                otpb_pkg::MODE_ADDR: begin
                    nxt_cur.mode = otpb_pkg::otpb_mode_type'(newMode[2:0]);
                end
                otpb_pkg::PCTRL_ADDR: begin
                    // Held stable while a step runs so the banks never
                    // see their target change mid-pulse.
                    if (stepIdle(cur_ff.phase)) begin
                        nxt_cur.pctrl = newPctrl;
                        if (cur_ff.mode == otpb_pkg::MODE_MAN_PROG) begin
                            nxt_cur.phase = otpb_pkg::PH_PULSE;
                            nxt_cur.cnt = PULSE_LAST;
                            nxt_cur.progErrU = 1'b0;
                            nxt_cur.progErrL = 1'b0;
                            nxt_cur.cmd.strobe = 1'b1;
                            nxt_cur.cmd.wordAddr =
                                newPctrl[otpb_pkg::WADDR_LSB +: 13];
                            nxt_cur.cmd.upperEnable =
                                newPctrl[otpb_pkg::ENU_BIT];
                            nxt_cur.cmd.upperBitValue =
                                newPctrl[otpb_pkg::BITU_BIT];
                            nxt_cur.cmd.upperWordBit = wordBit(1'b1,
                                newPctrl[otpb_pkg::BSELU_BIT],
                                newPctrl[otpb_pkg::BADRU_LSB +: 3]);
                            nxt_cur.cmd.lowerEnable =
                                newPctrl[otpb_pkg::ENL_BIT];
                            nxt_cur.cmd.lowerBitValue =
                                newPctrl[otpb_pkg::BITL_BIT];
                            nxt_cur.cmd.lowerWordBit = wordBit(1'b0,
                                newPctrl[otpb_pkg::BSELL_BIT],
                                newPctrl[otpb_pkg::BADRL_LSB +: 3]);
                        end
                    end
                end
                otpb_pkg::STAT_ADDR: begin
                    nxt_cur.rsp.bresp = otpb_pkg::RESP_OKAY;
                end
                default: begin
                    nxt_cur.rsp.bresp = otpb_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Read channel
        // Data is caught at acceptance and held,
        // so status fields never tear
        if (cur_ff.rsp.rvalid && axiReq.rready) begin
            nxt_cur.rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && cur_ff.rsp.arready) begin
            nxt_cur.rsp.rvalid = 1'b1;
            nxt_cur.rsp.rresp = otpb_pkg::RESP_OKAY;
            case (axiReq.araddr)
                otpb_pkg::MODE_ADDR: begin
                    nxt_cur.rsp.rdata = {29'h0, cur_ff.mode};
                end
                otpb_pkg::PCTRL_ADDR: begin
                    nxt_cur.rsp.rdata = cur_ff.pctrl;
                end
                otpb_pkg::STAT_ADDR: begin
                    nxt_cur.rsp.rdata = statusWord;
                end
                default: begin
                    nxt_cur.rsp.rdata = 32'h0000_0000;
                    nxt_cur.rsp.rresp = otpb_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Manual programming step: strobe for PROG_CYC cycles, then verify
        case (cur_ff.phase)
            otpb_pkg::PH_IDLE: begin
                // Wait for a commit above to start a step
            end
            otpb_pkg::PH_PULSE: begin
                // Counting down from PROG_CYC-1
                if (cur_ff.cnt == 16'h0000) begin
                    nxt_cur.phase = otpb_pkg::PH_VERIFY;
                    nxt_cur.cmd.strobe = 1'b0;
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 16'h0001;
                end
            end
            otpb_pkg::PH_VERIFY: begin
                // A disabled bank cannot be blamed for a failure
                nxt_cur.progErrU = macroUpperFail &
                                   cur_ff.cmd.upperEnable;
                nxt_cur.progErrL = macroLowerFail & cur_ff.cmd.lowerEnable;
                nxt_cur.phase = otpb_pkg::PH_IDLE;
            end
            default: begin
                nxt_cur.phase = otpb_pkg::PH_IDLE;
                nxt_cur.cmd.strobe = 1'b0;
            end
        endcase

        // One write and one read in flight at most
        // Taken from the next state so a slot is
        // never offered that cannot be taken
        nxt_cur.rsp.awready = ~nxt_cur.awPend & ~nxt_cur.rsp.bvalid;
        nxt_cur.rsp.wready = ~nxt_cur.wPend & ~nxt_cur.rsp.bvalid;
        nxt_cur.rsp.arready = ~nxt_cur.rsp.rvalid;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Readies come up high, so the first
    // request after release is taken at once
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cur_ff <= '0;
            cur_ff.pctrl <= otpb_pkg::PCTRL_RESET;
            cur_ff.mode <= otpb_pkg::MODE_STANDBY;
            cur_ff.phase <= otpb_pkg::PH_IDLE;
            cur_ff.rsp.awready <= 1'b1;
            cur_ff.rsp.wready <= 1'b1;
            cur_ff.rsp.arready <= 1'b1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs come straight from the state flops
    assign axiRsp = cur_ff.rsp;
    assign macroCmd = cur_ff.cmd;
    assign modeSel = cur_ff.mode;

endmodule

`default_nettype wire

// [hw/otpb_pkg.sv]
/*
 * Shared constants and carrier types of the bit-programming and status
 * block of the one-time-programmable memory controller.
 * Assumes a 25 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none

package otpb_pkg;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [31:0] MODE_ADDR = 32'h4000_8000;
    localparam logic [31:0] PCTRL_ADDR = 32'h4000_8004;
    localparam logic [31:0] STAT_ADDR = 32'h4000_8008;
    localparam logic [31:0] PCTRL_MASK = 32'h0FFF_1FFF;
    localparam logic [31:0] MODE_MASK = 32'h0000_0007;
    localparam logic [31:0] PCTRL_RESET = 32'h0000_0000;
    localparam int ENU_BIT = 27;
    localparam int BITU_BIT = 26;
    localparam int ENL_BIT = 25;
    localparam int BITL_BIT = 24;
    localparam int BSELU_BIT = 23;
    localparam int BADRU_LSB = 20;
    localparam int BSELL_BIT = 19;
    localparam int BADRL_LSB = 16;
    localparam int WADDR_LSB = 0;
    localparam int UPPER_HI_LSB = 24;
    localparam int LOWER_HI_LSB = 16;
    localparam int UPPER_LO_LSB = 8;
    localparam int LOWER_LO_LSB = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int PROG_TIME_NS = 1000;
    localparam int PROG_CYCLES =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_STANDBY = 3'h0, MODE_MAN_READ = 3'h1, MODE_MAN_PROG = 3'h2,
        MODE_AUTO_READ = 3'h3, MODE_AUTO_PROG = 3'h4,
        MODE_BLANK_TEST = 3'h5, MODE_DECODE_TEST = 3'h6,
        MODE_WRITE_TEST = 3'h7
    } otpb_mode_type;

    typedef enum logic [1:0] {
        PH_IDLE = 2'h0, PH_PULSE = 2'h1, PH_VERIFY = 2'h2
    } otpb_phase_type;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic awvalid; logic [31:0] awaddr;
        logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
        logic bready;
        logic arvalid; logic [31:0] araddr;
        logic rready;
    } otpb_axi_req_type;

    typedef struct packed {
        logic awready; logic wready;
        logic bvalid; logic [1:0] bresp;
        logic arready;
        logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } otpb_axi_rsp_type;

    typedef struct packed {
        logic strobe;
        logic [12:0] wordAddr;
        logic upperEnable; logic upperBitValue; logic [4:0] upperWordBit;
        logic lowerEnable; logic lowerBitValue; logic [4:0] lowerWordBit;
    } otpb_macro_cmd_type;

    typedef struct packed {
        logic [3:0] fifoWordCount;
        logic [12:0] wordsRemaining;
        logic autoBusy;
        logic autoProgStep;
        logic autoProgErrU;
        logic autoProgErrL;
        logic testBusy;
        logic testErrU;
        logic testErrL;
    } otpb_ctrl_in_type;

endpackage

`default_nettype wire
